// ==== logic/bil_boot_loader.sv ====
// Boot image loader: SPI slave, link and OTP boot, security word
`timescale 1ns/1ps
`default_nettype none
`include "bil_boot_regs.svh"
module bil_boot_loader
    import bil_boot_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire bil_src_t    bootSel,
    input  wire logic        spiSclk,
    input  wire logic        spiSelN,
    input  wire logic        spiMosi,
    output logic             spiPinEn,
    output logic             linkEn,
    output logic             linkPullDn,
    output logic [4:0]       linkTxWire,
    input  wire logic [4:0]  linkRxWire,
    output logic             linkRxBad,
    input  wire bil_rx_t     linkRx,
    output logic             linkRxReady,
    output bil_tx_t          linkTx,
    input  wire logic        linkTxReady,
    output logic             chanEnd0Alloc,
    output logic             otpRdEn,
    output logic             otpRdSec,
    output logic [10:0]      otpRdAddr,
    input  wire logic [31:0] otpRdData,
    input  wire logic        otpRdValid,
    input  wire bil_res_t    resWr,
    output logic             otpPgmEn,
    output logic             otpPgmSec,
    output logic [15:0]      otpPgmAddr,
    output logic [31:0]      otpPgmData,
    output logic             otpPgmRefused,
    input  wire logic        dbgOtpReq,
    output logic             dbgOtpGrant,
    output logic             dbgPortDis,
    output logic             switchAccessDis,
    output logic             otpRedundantEn,
    output logic [31:0]      secCfg,
    output logic [6:0]       userField,
    output logic [9:0]       userIdExt,
    output bil_img_t         img,
    output logic             bootJump,
    output logic             bootFail,
    output logic             bootDone
);

    bil_spi_t  q;
    bil_spi_t  next_q;
    bil_core_t s;
    bil_core_t next_s;
    logic      byteEv;
    logic      selRise;

    // CRC over one word, most significant bit first
    function automatic logic [31:0] bilCrc(input logic [31:0] c,
                                           input logic [31:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 31; i >= 0; i--) begin
            r = {r[30:0], 1'b0} ^
                ((r[31] ^ d[i]) ? `BIL_CRC_POLY : 32'h0);
        end
        return r;
    endfunction

    // Held word goes to SRAM and the CRC, new word is held back
    function automatic bil_core_t bilTake(input bil_core_t c,
                                          input logic [31:0] w);
        bil_core_t r;
        r = c;
        if (c.hasPrev) begin
            r.we    = 1'b1;
            r.wa    = c.wcnt;
            r.wdata = c.prev;
            r.wcnt  = c.wcnt + 16'h0001;
            r.crc   = bilCrc(c.crc, c.prev);
        end
        r.prev    = w;
        r.hasPrev = 1'b1;
        return r;
    endfunction

    // Programming allowed only while the master lock and, for a non-security write, the sector lock are clear
    function automatic logic bilPgmOk(input logic [31:0] sc,
                                      input logic [15:0] a,
                                      input logic        toSec);
        logic ok;
        ok = !sc[`BIL_SEC_MLOCK];
        if (!toSec) begin
            ok = ok && !sc[`BIL_SEC_LOCK0 +
                           a[`BIL_ROW_W-1:`BIL_SECT_LSB]];
        end
        return ok;
    endfunction

    // Serial side: shift on the rising edge of the master's clock
    always_comb begin
        next_q    = q;
        next_q.rs = {q.rs[0], rst_n};
        if (!q.rs[1]) begin
            next_q.bitCnt  = 3'h0;
            next_q.sh      = 8'h00;
            next_q.byteReg = 8'h00;
            next_q.tog     = 1'b0;
        end else if (!spiSelN) begin
            // Modes 0/0 and 1/1 both sample on the rising edge
            next_q.sh     = {spiMosi, q.sh[7:1]};
            next_q.bitCnt = q.bitCnt + 3'h1;
            if (q.bitCnt == 3'h7) begin
                next_q.byteReg = {spiMosi, q.sh[7:1]};
                next_q.tog     = ~q.tog;
            end
        end
    end

    always_ff @(posedge spiSclk) begin
        q <= next_q;
    end

    assign byteEv  = s.togS[1] ^ s.togLast;
    assign selRise = s.selS[1] & ~s.selLast;

    // Core side: boot sequencing and security control
    always_comb begin
        next_s         = s;
        next_s.we      = 1'b0;
        next_s.jump    = 1'b0;
        next_s.pgm     = 1'b0;
        next_s.pgmNo   = 1'b0;
        next_s.selS    = {s.selS[0], spiSelN};
        next_s.selLast = s.selS[1];
        next_s.togS    = {s.togS[0], q.tog};
        next_s.togLast = s.togS[1];
        next_s.rxA     = linkRxWire;
        next_s.rxB     = s.rxA;
        // Remote side must hold its wires low once enabled
        if (s.linkOn && (s.rxB != 5'h00)) begin
            next_s.rxBad = 1'b1;
        end
        // Programming ports, decoded by resource identifier
        if (resWr.en) begin
            case (resWr.id)
                `BIL_RES_PADDR: begin
                    next_s.pAddr = resWr.data[15:0];
                end
                `BIL_RES_PDATA: begin
                    next_s.pData = resWr.data;
                end
                `BIL_RES_PCTL: begin
                    if (resWr.data[`BIL_PCTL_GO]) begin
                        next_s.pgmSec = resWr.data[`BIL_PCTL_SEC];
                        if (bilPgmOk(s.sec, s.pAddr,
                                     resWr.data[`BIL_PCTL_SEC])) begin
                            next_s.pgm = 1'b1;
                        end else begin
                            next_s.pgmNo = 1'b1;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
        case (s.st)
            ST_SECLD: begin
                // Security word before any boot step depends on it
                if (otpRdValid) begin
                    next_s.sec = otpRdData;
                    next_s.row = 11'h000;
                    next_s.st  = ST_OTPLEN;
                end
            end
            ST_OTPLEN: begin
                // Row 0 holds the length of an OTP program
                if (otpRdValid) begin
                    next_s.len = otpRdData[10:0];
                    next_s.row = 11'h001;
                    if (otpRdData[10:0] != 11'h000) begin
                        next_s.st = ST_OTPCP;
                    end else if (s.sec[`BIL_SEC_SECBOOT]) begin
                        next_s.fail = 1'b1;
                        next_s.st   = ST_FAIL;
                    end else begin
                        next_s.st = ST_PICK;
                    end
                end
            end
            ST_OTPCP: begin
                // Copy OTP program to SRAM, then run it first
                if (otpRdValid) begin
                    next_s.we    = 1'b1;
                    next_s.wa    = s.wcnt;
                    next_s.wdata = otpRdData;
                    next_s.wcnt  = s.wcnt + 16'h0001;
                    if (s.row == s.len) begin
                        next_s.jump = 1'b1;
                        next_s.st   = ST_DONE;
                    end else begin
                        next_s.row = s.row + 11'h001;
                    end
                end
            end
            ST_PICK: begin
                case (bootSel)
                    SRC_SPI: begin
                        next_s.st = ST_SPI;
                    end
                    SRC_LINK: begin
                        next_s.viaLink = 1'b1;
                        next_s.dly = 8'(`BIL_LINK_EN_CYC - 1);
                        next_s.st  = ST_LDLY;
                    end
                    default: begin
                    end
                endcase
            end
            ST_SPI: begin
                // Bytes pack little-endian into words
                if (byteEv) begin
                    next_s.wbuf = {q.byteReg, s.wbuf[31:8]};
                    next_s.bidx = s.bidx + 2'h1;
                    if (s.bidx == 2'h3) begin
                        next_s = bilTake(next_s,
                                         {q.byteReg, s.wbuf[31:8]});
                    end
                end else if (selRise && s.hasPrev) begin
                    next_s.st = ST_CHECK;
                end
            end
            ST_LDLY: begin
                if (s.dly == 8'h00) begin
                    next_s.linkOn = 1'b1;
                    next_s.st     = ST_LACK;
                end else begin
                    next_s.dly = s.dly - 8'h01;
                end
            end
            ST_LACK: begin
                // First data word names the acknowledge channel
                if (linkRx.valid && !linkRx.ctl) begin
                    next_s.ack = linkRx.word;
                    next_s.st  = ST_LIMG;
                end
            end
            ST_LIMG: begin
                // Image words with CRC, closed by an END token
                if (linkRx.valid) begin
                    if (!linkRx.ctl) begin
                        next_s = bilTake(next_s, linkRx.word);
                    end else if (linkRx.word[7:0] == `BIL_TOK_END) begin
                        next_s.st = ST_CHECK;
                    end
                end
            end
            ST_CHECK: begin
                // Last word held back is the image CRC
                if (!s.hasPrev || (s.prev != s.crc)) begin
                    next_s.fail = 1'b1;
                    next_s.st   = ST_FAIL;
                end else if (s.viaLink &&
                             (s.ack != `BIL_NULL_CHAN)) begin
                    next_s.st = ST_LSEND;
                end else begin
                    next_s.jump = 1'b1;
                    next_s.st   = ST_DONE;
                end
            end
            ST_LSEND: begin
                if (linkTxReady) begin
                    next_s.jump = 1'b1;
                    next_s.st   = ST_DONE;
                end
            end
            ST_FAIL, ST_DONE: begin
            end
            default: begin
                next_s.st = ST_FAIL;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s     <= '0;
            s.crc <= `BIL_CRC_INIT;
            s.selS    <= 2'h3; // Select idles high, no false edge
            s.selLast <= 1'h1;
        end else begin
            s <= next_s;
        end
    end

    // Pins and link control
    assign spiPinEn   = (s.st == ST_SPI);
    assign linkEn     = s.linkOn;
    assign linkPullDn = ~s.linkOn;
    assign linkTxWire = 5'h00;
    assign linkRxBad  = s.rxBad;
    assign linkRxReady = (s.st == ST_LACK) || (s.st == ST_LIMG);
    assign chanEnd0Alloc = s.viaLink && ((s.st == ST_LACK) ||
        (s.st == ST_LIMG) || (s.st == ST_CHECK) ||
        (s.st == ST_LSEND));

    // END token towards the acknowledge channel
    assign linkTx.valid = (s.st == ST_LSEND);
    assign linkTx.ctl   = 1'b1;
    assign linkTx.dest  = s.ack;
    assign linkTx.word  = {24'h000000, `BIL_TOK_END};

    // OTP reads for security word and program copy
    assign otpRdEn   = (s.st == ST_SECLD) || (s.st == ST_OTPLEN) ||
                       (s.st == ST_OTPCP);
    assign otpRdSec  = (s.st == ST_SECLD);
    assign otpRdAddr = s.row;

    // Programming strobe and its operands
    assign otpPgmEn      = s.pgm;
    assign otpPgmSec     = s.pgmSec;
    assign otpPgmAddr    = s.pAddr;
    assign otpPgmData    = s.pData;
    assign otpPgmRefused = s.pgmNo;

    // Security features decoded from the loaded word
    assign secCfg          = s.sec;
    assign dbgPortDis      = s.sec[`BIL_SEC_DBG_DIS];
    assign switchAccessDis = s.sec[`BIL_SEC_SW_DIS];
    assign otpRedundantEn  = s.sec[`BIL_SEC_REDUND];
    assign dbgOtpGrant     = dbgOtpReq && !s.sec[`BIL_SEC_DBGOTP] &&
                             !s.sec[`BIL_SEC_DBG_DIS];
    assign userField = s.sec[`BIL_SEC_USER_HI:`BIL_SEC_USER_LO];
    assign userIdExt = s.sec[`BIL_SEC_UID_HI:`BIL_SEC_UID_LO];

    // Image write port and boot status
    assign img.we   = s.we;
    assign img.addr = s.wa;
    assign img.data = s.wdata;
    assign bootJump = s.jump;
    assign bootFail = s.fail;
    assign bootDone = (s.st == ST_DONE);

    a_spi_sample: assert property (
        @(posedge spiSclk) disable iff (!q.rs[1])
        !spiSelN |=> q.sh[7] == $past(spiMosi))
        else $error("serial bit not taken on rising edge");

    a_lsb_first: assert property (
        @(posedge spiSclk) disable iff (!q.rs[1])
        (!spiSelN && q.bitCnt == 3'h7) |=>
            (q.byteReg[7] == $past(spiMosi)) &&
            (q.byteReg[0] == $past(q.sh[1])))
        else $error("byte not assembled lsb first");

    a_link_delay: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        $rose(s.st == ST_LDLY) |-> !linkEn [*8])
        else $error("link enabled too early");

    a_link_pins: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        linkEn |-> (!linkPullDn && linkTxWire == 5'h00))
        else $error("link pins not in enabled state");

    a_ack_word: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (s.st == ST_LACK && linkRx.valid && !linkRx.ctl) |=>
            (s.ack == $past(linkRx.word)) && chanEnd0Alloc)
        else $error("ack channel word not kept");

    a_end_sent: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (linkTx.valid && linkTxReady) |=>
            bootJump && !chanEnd0Alloc)
        else $error("no jump or end 0 kept after END");

    a_dbg_block: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        s.sec[`BIL_SEC_DBG_DIS] |-> (dbgPortDis && !dbgOtpGrant))
        else $error("debug port reachable while disabled");

    a_master_lock: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        $past(s.sec[`BIL_SEC_MLOCK]) |-> !otpPgmEn)
        else $error("programming under master lock");

    a_secure_boot: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        s.sec[`BIL_SEC_SECBOOT] |-> (!spiPinEn && !linkEn))
        else $error("other source used under secure boot");

    a_crc_refuse: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        bootFail |-> !bootJump ##1 !bootJump)
        else $error("jump after failed boot");

endmodule
`default_nettype wire

// ==== logic/bil_boot_pkg.sv ====
// Types of the boot image loader and security block
`default_nettype none
package bil_boot_pkg;
    typedef enum logic [1:0] {SRC_NONE, SRC_SPI, SRC_LINK} bil_src_t;
    typedef enum logic [3:0] {
        ST_SECLD, ST_OTPLEN, ST_OTPCP, ST_PICK, ST_SPI, ST_LDLY,
        ST_LACK, ST_LIMG, ST_CHECK, ST_LSEND, ST_FAIL, ST_DONE
    } bil_state_t;
    typedef struct packed {
        logic        valid;
        logic        ctl;
        logic [31:0] word;
    } bil_rx_t;
    typedef struct packed {
        logic        valid;
        logic        ctl;
        logic [31:0] dest;
        logic [31:0] word;
    } bil_tx_t;
    typedef struct packed {
        logic        we;
        logic [15:0] addr;
        logic [31:0] data;
    } bil_img_t;
    typedef struct packed {
        logic        en;
        logic [23:0] id;
        logic [31:0] data;
    } bil_res_t;
    typedef struct packed {
        logic [1:0] rs;
        logic [2:0] bitCnt;
        logic [7:0] sh;
        logic [7:0] byteReg;
        logic       tog;
    } bil_spi_t;
    typedef struct packed {
        bil_state_t  st;
        logic        viaLink;
        logic        linkOn;
        logic [31:0] sec;
        logic [31:0] ack;
        logic [31:0] crc;
        logic [31:0] prev;
        logic        hasPrev;
        logic [31:0] wbuf;
        logic [1:0]  bidx;
        logic [10:0] row;
        logic [10:0] len;
        logic [7:0]  dly;
        logic [15:0] wcnt;
        logic [15:0] wa;
        logic        we;
        logic [31:0] wdata;
        logic        jump;
        logic        fail;
        logic [1:0]  selS;
        logic        selLast;
        logic [1:0]  togS;
        logic        togLast;
        logic [4:0]  rxA;
        logic [4:0]  rxB;
        logic        rxBad;
        logic [15:0] pAddr;
        logic [31:0] pData;
        logic        pgm;
        logic        pgmSec;
        logic        pgmNo;
    } bil_core_t;
endpackage
`default_nettype wire

// ==== logic/bil_boot_regs.svh ====
// Constants of the boot image loader and security block
`ifndef BIL_BOOT_REGS_SVH
`define BIL_BOOT_REGS_SVH

`define BIL_SEC_DBG_DIS  0
`define BIL_SEC_SW_DIS   1
`define BIL_SEC_SECBOOT  5
`define BIL_SEC_REDUND   7
`define BIL_SEC_LOCK0    8
`define BIL_SEC_MLOCK    12
`define BIL_SEC_DBGOTP   13
`define BIL_SEC_USER_LO  15
`define BIL_SEC_USER_HI  21
`define BIL_SEC_UID_LO   22
`define BIL_SEC_UID_HI   31

`define BIL_ROW_W        11
`define BIL_SECT_LSB     9
`define BIL_RES_PADDR    24'h100200
`define BIL_RES_PDATA    24'h200100
`define BIL_RES_PCTL     24'h100300
`define BIL_PCTL_GO      0
`define BIL_PCTL_SEC     1

`define BIL_NULL_CHAN    32'h0000FF02
`define BIL_TOK_END      8'h01
`define BIL_CRC_POLY     32'h04C11DB7
`define BIL_CRC_INIT     32'hFFFFFFFF

`define BIL_CLK_NS       8
`define BIL_LINK_EN_NS   2000
`define BIL_LINK_EN_CYC  (`BIL_LINK_EN_NS / `BIL_CLK_NS)

`endif

// ==== test/bil_spi_master.sv ====
// SPI boot master model that clocks a boot image into the slave port
`timescale 1ns/1ps
`default_nettype none
module bil_spi_master (
    output logic spiSclk,
    output logic spiSelN,
    output logic spiMosi
);
    // Lines start released: clock parked low, select high
    initial begin
        spiSclk = 1'h0;
        spiSelN = 1'h1;
        spiMosi = 1'h1;
    end

    // Edges with select high carry rst_n into the serial domain reset, setting or clearing it
    task automatic idle(input int n);
        repeat (n) begin
            #62.5 spiSclk = 1'h1;
            #62.5 spiSclk = 1'h0;
        end
    endtask

    // One frame; mode 1/1 parks the clock high, data moves on the fall
    task automatic frame(input logic m11, input logic [7:0] q[$]);
        spiSclk = m11;
        #62.5 spiSelN = 1'h0;
        foreach (q[i]) begin
            for (int b = 0; b < 8; b++) begin
                #62.5 spiSclk = 1'h0;
                spiMosi = q[i][b];
                #62.5 spiSclk = 1'h1;
            end
        end
        #62.5 spiSclk = m11;
        spiMosi = ~spiMosi;
        #62.5 spiSelN = 1'h1;
    endtask
endmodule
`default_nettype wire

// ==== test/tb_boot_image_loader.sv ====
// Self-checking bench of the boot image loader
`timescale 1ns/1ps
`default_nettype none
`include "bil_boot_regs.svh"
module tb_boot_image_loader
    import bil_boot_pkg::*;
;
    typedef struct packed {
        logic [15:0] a;
        logic        sec;
        logic        ok;
    } bil_pgm_row_t;

    logic         core_clk = 1'h0;
    logic         rst_n = 1'h0;
    bil_src_t     bootSel = SRC_NONE;
    logic         spiSclk, spiSelN, spiMosi, spiPinEn, linkEn, linkPullDn;
    logic         linkRxBad, linkRxReady, linkTxReady, chanEnd0Alloc;
    logic         otpRdEn, otpRdSec, otpRdValid, otpPgmEn, otpPgmSec;
    logic         otpPgmRefused, dbgOtpReq, dbgOtpGrant, dbgPortDis;
    logic         switchAccessDis, otpRedundantEn, bootJump, bootFail;
    logic         bootDone;
    logic [4:0]   linkTxWire, linkRxWire;
    logic [10:0]  otpRdAddr;
    logic [15:0]  otpPgmAddr;
    logic [31:0]  otpRdData, otpPgmData, secCfg, secWord;
    logic [6:0]   userField;
    logic [9:0]   userIdExt;
    bil_rx_t      linkRx;
    bil_tx_t      linkTx;
    bil_res_t     resWr;
    bil_img_t     img;
    logic [31:0]  otp [0:3];
    logic [47:0]  imgQ [$];
    logic [31:0]  wq [$] = '{32'h1234_5678, 32'hCAFE_0001};
    int           miscompares = 0;
    int           num_checks = 0;
    int           jumps = 0;
    int           sends = 0;
    int           since = 0;
    bil_pgm_row_t rows [4] = '{'{16'h0010, 1'h0, 1'h0},
        '{16'h0210, 1'h0, 1'h1}, '{16'h0010, 1'h1, 1'h1},
        '{16'h0610, 1'h0, 1'h0}};

    bil_boot_loader uut (.*);
    bil_spi_master  mst (.*);

    initial forever #4 core_clk = ~core_clk;

    // OTP answers a held read with a one-cycle valid
    always @(negedge core_clk) begin
        otpRdValid <= rst_n && otpRdEn && !otpRdValid; // Quiet in reset
        otpRdData <= otpRdSec ? secWord : otp[otpRdAddr[1:0]];
    end

    // Collect image writes, jumps and cycles since release
    always @(posedge core_clk) begin
        if (img.we === 1'h1) imgQ.push_back({img.addr, img.data});
        if (bootJump === 1'h1) jumps++;
        if (linkTx.valid === 1'h1) sends++;
        since <= rst_n ? since + 1 : 0;
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t ns got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic tk(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task automatic endt(input string s);
        $display("test %s done, checks %0d", s, num_checks);
    endtask

    function automatic logic [31:0] crcOf(input logic [31:0] q[$]);
        logic [31:0] c = `BIL_CRC_INIT;
        foreach (q[i]) begin
            for (int b = 31; b >= 0; b--) begin
                c = {c[30:0], 1'h0}
                    ^ ((c[31] ^ q[i][b]) ? `BIL_CRC_POLY : 32'h0);
            end
        end
        return c;
    endfunction

    // Reset, then check the security word taken from OTP
    task automatic boot(input logic [31:0] s, input logic [31:0] l,
                        input bil_src_t src);
        secWord = s;
        otp[0] = l;
        imgQ.delete();
        rst_n <= 1'h0;
        bootSel <= src;
        dbgOtpReq <= 1'h1;
        mst.idle(3); // Serial domain takes its reset too
        tk(20);
        chk({bootJump, linkEn, otpPgmEn, secCfg}, 64'h0);
        rst_n <= 1'h1;
        tk(1);
        chk({otpRdEn, otpRdSec}, 2'h3);
        for (int n = 0; n < 20 && otpRdSec === 1'h1; n++) tk(1);
        tk(2);
        chk(secCfg, s);
        chk(otpRdAddr, 11'h001);
        chk({dbgPortDis, switchAccessDis, otpRedundantEn},
            {s[0], s[1], s[7]});
        chk({userField, userIdExt}, {s[21:15], s[31:22]});
        chk(dbgOtpGrant, !s[13] && !s[0]);
        jumps = 0;
        sends = 0;
    endtask

    // Address, data and go writes through the programming ports
    task automatic pgm(input logic [15:0] a, input logic sec, input logic ok);
        logic        en = 1'h0;
        logic        rf = 1'h0;
        logic [63:0] seen = 64'h0;
        resWr <= '{1'h1, `BIL_RES_PADDR, {16'h0, a}};
        tk(1);
        resWr <= '{1'h1, `BIL_RES_PDATA, {a, ~a}};
        tk(1);
        resWr <= '{1'h1, `BIL_RES_PCTL, {30'h0, sec, 1'h1}};
        tk(1);
        resWr <= '0;
        repeat (3) begin
            if (otpPgmEn === 1'h1) seen = {otpPgmSec, otpPgmAddr, otpPgmData};
            en = en | (otpPgmEn === 1'h1);
            rf = rf | (otpPgmRefused === 1'h1);
            tk(1);
        end
        chk({en, rf}, {ok, !ok});
        if (ok) chk(seen, {sec, a, a, ~a});
    endtask

    // One link word or token, held until the loader takes it
    task automatic lsend(input logic c, input logic [31:0] w);
        linkRx <= '{1'h1, c, w};
        for (int n = 0; n < 50 && linkRxReady !== 1'h1; n++) tk(1);
        tk(1);
    endtask

    // Image words then CRC, bytes low first, as one select frame
    task automatic spiImg(input logic m11, input logic bad);
        logic [7:0]  b [$];
        logic [31:0] c;
        c = crcOf(wq) ^ {31'h0, bad};
        foreach (wq[i]) for (int k = 0; k < 4; k++) b.push_back(wq[i][8*k+:8]);
        for (int k = 0; k < 4; k++) b.push_back(c[8*k+:8]);
        mst.idle(4);
        mst.frame(m11, b);
        for (int n = 0; n < 99 && !bootDone && !bootFail; n++) tk(1);
        tk(2);
    endtask

    task automatic chkImg();
        chk(imgQ.size(), wq.size());
        foreach (wq[i]) begin
            if (i < imgQ.size()) chk(imgQ[i], {i[15:0], wq[i]});
        end
    endtask

    initial begin
        linkRxWire = 5'h0;
        linkRx = '0;
        linkTxReady = 1'h0;
        resWr = '0;
        dbgOtpReq = 1'h0;
        otp = '{default: 32'h0};
        // Link boot with programming-port rows
        boot(32'hA5A0_0982, 32'h0, SRC_LINK);
        foreach (rows[i]) pgm(rows[i].a, rows[i].sec, rows[i].ok);
        chk({linkEn, linkPullDn, linkRxReady}, 3'h2);
        for (int n = 0; n < 400 && linkEn !== 1'h1; n++) tk(1);
        chk(since >= 250 && since <= 270, 1'h1);
        chk({linkPullDn, linkTxWire}, 6'h0);
        lsend(1'h1, 32'h7);
        lsend(1'h0, 32'h0000_0123);
        chk(chanEnd0Alloc, 1'h1);
        foreach (wq[i]) lsend(1'h0, wq[i]);
        lsend(1'h0, crcOf(wq));
        lsend(1'h1, 32'h5);
        lsend(1'h1, {24'h0, `BIL_TOK_END});
        linkRx <= '{1'h0, 1'h0, 32'hA5A5_A5A5};
        for (int n = 0; n < 20 && linkTx.valid !== 1'h1; n++) tk(1);
        tk(3);
        chk({linkTx.valid, linkTx.ctl, linkTx.dest, linkTx.word[7:0], bootJump},
            {2'h3, 32'h0000_0123, `BIL_TOK_END, 1'h0});
        linkTxReady <= 1'h1;
        for (int n = 0; n < 20 && bootDone !== 1'h1; n++) tk(1);
        tk(1);
        chk({jumps == 1, chanEnd0Alloc, bootDone, bootFail}, 4'hA);
        chkImg();
        linkTxReady <= 1'h0;
        linkRxWire <= 5'h4;
        tk(4);
        chk(linkRxBad, 1'h1);
        linkRxWire <= 5'h0;
        endt("link");
        // Link boot whose host asks for no acknowledgement
        boot(32'h0, 32'h0, SRC_LINK);
        for (int n = 0; n < 400 && linkEn !== 1'h1; n++) tk(1);
        lsend(1'h0, `BIL_NULL_CHAN);
        foreach (wq[i]) lsend(1'h0, wq[i]);
        lsend(1'h0, crcOf(wq));
        lsend(1'h1, {24'h0, `BIL_TOK_END});
        linkRx <= '0;
        tk(3);
        chk({jumps == 1, sends == 0, bootDone}, 3'h7);
        chkImg();
        endt("nullack");
        // SPI mode 0/0 with a master lock in force
        boot(32'h0000_1000, 32'h0, SRC_SPI);
        pgm(16'h0210, 1'h0, 1'h0);
        pgm(16'h0010, 1'h1, 1'h0);
        chk({spiPinEn, linkEn}, 2'h2);
        spiImg(1'h0, 1'h0);
        chk({jumps == 1, bootDone, bootFail}, 3'h6);
        chkImg();
        endt("spi00");
        // SPI mode 1/1 carrying a corrupt CRC
        boot(32'h0000_2000, 32'h0, SRC_SPI);
        spiImg(1'h1, 1'h1);
        chk({jumps == 0, bootDone, bootFail}, 3'h5);
        chkImg();
        endt("spi11");
        // Secure boot copies OTP rows and ignores the link
        otp[1] = wq[0];
        otp[2] = wq[1];
        boot(32'h0000_0021, 32'h2, SRC_LINK);
        for (int n = 0; n < 60 && bootDone !== 1'h1; n++) tk(1);
        tk(2);
        chk({jumps == 1, bootDone, linkEn, spiPinEn}, 4'hC);
        chkImg();
        endt("otp");
        final_report();
    end

    // Watchdog well beyond the expected run length
    initial begin
        #400000;
        miscompares++;
        final_report();
    end
endmodule
`default_nettype wire
